/* atb_acq_top.sv */
// Added by the designer: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/10ps
module atb_acq_top #(
  parameter int NCH = 4,
  parameter int RAW_W = 26,
  parameter int FIFO_DEPTH = atb_pkg::FIFO_DEPTH_DEF
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Converter scan input
  input wire logic adc_scan_valid,
  input wire logic [NCH*RAW_W-1:0] adc_raw,
  // External trigger pin
  input wire logic ext_trig,
  // Sample stream to host
  output logic host_valid,
  output logic [atb_pkg::SAMPLE_W-1:0] host_data,
  input wire logic host_ready,
  // Events and lamp
  output logic buf_done,
  output logic buf_partial,
  output logic overrun_evt,
  output logic led_amber,
  output logic led_green
);
  localparam int SW = atb_pkg::SAMPLE_W;
  localparam int CW = atb_pkg::CNT_W;
  localparam int LW = $clog2(FIFO_DEPTH) + 1;
  localparam logic signed [RAW_W:0] SUM_OFS = (RAW_W+1)'(atb_pkg::CODE_MID);
  localparam logic signed [RAW_W:0] SUM_MAX = (RAW_W+1)'(atb_pkg::CODE_POS_FS);

  atb_pkg::atb_state_t state_reg;
  logic [atb_pkg::SRC_W-1:0] start_src_reg;
  logic [atb_pkg::SRC_W-1:0] ref_src_reg;
  logic [atb_pkg::CH_SEL_W-1:0] thr_ch_reg;
  logic [SW-1:0] level_reg;
  logic [NCH-1:0] chmask_reg;
  logic [31:0] postcnt_reg;
  logic [31:0] bufsize_reg;
  logic [CW-1:0] credits_reg;
  logic [31:0] buf_cnt_reg;
  logic [31:0] post_seen_reg;
  logic [CW-1:0] bufs_done_reg;
  logic overrun_reg;
  logic nobuf_reg;
  logic cfgerr_reg;
  logic ext_s1_reg;
  logic ext_s2_reg;
  logic ext_s3_reg;
  logic [SW-1:0] prev_reg;
  logic prev_ok_reg;
  logic [SW-1:0] scan_reg [NCH];
  logic [NCH-1:0] pend_reg;
  logic dp_pend_reg;
  logic dp_write_reg;
  logic dp_word_reg;
  logic [atb_pkg::ADDR_W-1:0] dp_addr_reg;

  // Offset-binary conversion with clamping, one per channel
  logic [SW-1:0] code_c [NCH];
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_conv
      logic signed [RAW_W:0] sum_c;
      assign sum_c = $signed({adc_raw[g*RAW_W+RAW_W-1], adc_raw[g*RAW_W +: RAW_W]}) + SUM_OFS;
      assign code_c[g] = (sum_c < 0) ? atb_pkg::CODE_NEG_FS :
                         (sum_c > SUM_MAX) ? atb_pkg::CODE_POS_FS :
                         sum_c[SW-1:0];
    end
  endgenerate

  // External trigger synchroniser and edge detect
  logic ext_rise_c;
  logic ext_fall_c;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
      ext_s3_reg <= 1'b0;
    end else begin
      ext_s1_reg <= ext_trig;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
    end
  end
  assign ext_rise_c = ext_s2_reg && !ext_s3_reg;
  assign ext_fall_c = !ext_s2_reg && ext_s3_reg;

  // Threshold crossing on the selected channel
  logic [SW-1:0] thr_code_c;
  logic thr_up_c;
  logic thr_dn_c;
  assign thr_code_c = code_c[thr_ch_reg[$clog2(NCH)-1:0]];
  assign thr_up_c = adc_scan_valid && prev_ok_reg && (prev_reg <= level_reg) &&
                    (thr_code_c > level_reg);
  assign thr_dn_c = adc_scan_valid && prev_ok_reg && (prev_reg >= level_reg) &&
                    (thr_code_c < level_reg);

  function automatic logic hit(input logic [atb_pkg::SRC_W-1:0] src, input logic rise,
                               input logic fall, input logic up, input logic dn);
    logic r;
    r = 1'b0;
    if (src == atb_pkg::SRC_EXT_POS) r = rise;
    if (src == atb_pkg::SRC_EXT_NEG) r = fall;
    if (src == atb_pkg::SRC_THR_POS) r = up;
    if (src == atb_pkg::SRC_THR_NEG) r = dn;
    return r;
  endfunction

  logic start_hit_c;
  logic ref_hit_c;
  assign start_hit_c = hit(start_src_reg, ext_rise_c, ext_fall_c, thr_up_c, thr_dn_c);
  assign ref_hit_c = hit(ref_src_reg, ext_rise_c, ext_fall_c, thr_up_c, thr_dn_c);

  // Register bus decode
  logic wr_en_c;
  logic start_cmd_c;
  logic abort_cmd_c;
  assign wr_en_c = dp_pend_reg && dp_write_reg && dp_word_reg;
  assign start_cmd_c = wr_en_c && (dp_addr_reg == atb_pkg::OFF_CTRL) &&
                       hwdata[atb_pkg::CTRL_START_BIT];
  assign abort_cmd_c = wr_en_c && (dp_addr_reg == atb_pkg::OFF_CTRL) &&
                       hwdata[atb_pkg::CTRL_ABORT_BIT];

  // Start acceptance and configuration check
  logic idle_c;
  logic uses_thr_c;
  logic cfg_ok_c;
  logic go_c;
  assign idle_c = (state_reg == atb_pkg::ATB_IDLE) || (state_reg == atb_pkg::ATB_HALT);
  assign uses_thr_c = (start_src_reg >= atb_pkg::SRC_THR_POS) ||
                      (ref_src_reg >= atb_pkg::SRC_THR_POS);
  assign cfg_ok_c = (chmask_reg != '0) && (!uses_thr_c ||
                    ((thr_ch_reg < atb_pkg::CH_SEL_W'(NCH)) &&
                     chmask_reg[thr_ch_reg[$clog2(NCH)-1:0]]));
  assign go_c = start_cmd_c && idle_c && cfg_ok_c;

  // Scan capture and channel serialiser
  logic acq_c;
  logic scan_take_c;
  logic push_c;
  logic fifo_wr_ready;
  logic [SW-1:0] push_data_c;
  logic [NCH-1:0] push_bit_c;
  assign acq_c = (state_reg == atb_pkg::ATB_PRE) || (state_reg == atb_pkg::ATB_POST) ||
                 (state_reg == atb_pkg::ATB_RUN);
  assign scan_take_c = adc_scan_valid && acq_c && !abort_cmd_c;
  assign push_c = (pend_reg != '0) && (acq_c || (state_reg == atb_pkg::ATB_FLUSH));

  always_comb begin
    push_data_c = scan_reg[0];
    push_bit_c = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (pend_reg[i]) begin
        push_data_c = scan_reg[i];
        push_bit_c = NCH'(1) << i;
      end
    end
  end

  // Overrun, buffer accounting and stop conditions
  logic overrun_c;
  logic take_c;
  logic buf_last_c;
  logic nobuf_stop_c;
  logic flush_end_c;
  logic partial_c;
  logic fifo_clear_c;
  logic drain_allow_c;
  logic [LW-1:0] fifo_level;
  assign overrun_c = !abort_cmd_c && ((scan_take_c && (pend_reg != '0)) ||
                     (push_c && !fifo_wr_ready));
  assign take_c = host_valid && host_ready;
  assign buf_last_c = take_c && (buf_cnt_reg == bufsize_reg - 32'h1);
  assign nobuf_stop_c = buf_last_c && (credits_reg == CW'(1));
  assign flush_end_c = (state_reg == atb_pkg::ATB_FLUSH) && (pend_reg == '0) &&
                       (fifo_level == '0) && !host_valid;
  assign partial_c = (abort_cmd_c || flush_end_c) && (buf_cnt_reg != '0) && !take_c;
  assign fifo_clear_c = go_c || abort_cmd_c || overrun_c || nobuf_stop_c;
  assign drain_allow_c = (credits_reg != '0) && !nobuf_stop_c &&
                         (state_reg != atb_pkg::ATB_HALT);

  atb_fifo #(
    .W(SW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(hclk),
    .rst_n(hresetn),
    .clear(fifo_clear_c),
    .wr_valid(push_c),
    .wr_data(push_data_c),
    .wr_ready(fifo_wr_ready),
    .rd_allow(drain_allow_c),
    .rd_valid(host_valid),
    .rd_data(host_data),
    .rd_ready(host_ready),
    .level(fifo_level)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_reg <= '0;
    end else if (fifo_clear_c) begin
      pend_reg <= '0;
    end else if (scan_take_c) begin
      pend_reg <= chmask_reg;
    end else if (push_c && fifo_wr_ready) begin
      pend_reg <= pend_reg & ~push_bit_c;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NCH; i++) begin
        scan_reg[i] <= '0;
      end
    end else if (scan_take_c && !overrun_c) begin
      for (int i = 0; i < NCH; i++) begin
        scan_reg[i] <= code_c[i];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_reg <= '0;
      prev_ok_reg <= 1'b0;
    end else if (go_c) begin
      prev_ok_reg <= 1'b0;
    end else if (adc_scan_valid) begin
      prev_reg <= thr_code_c;
      prev_ok_reg <= 1'b1;
    end
  end

  // Acquisition sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= atb_pkg::ATB_IDLE;
    end else if (abort_cmd_c) begin
      state_reg <= atb_pkg::ATB_IDLE;
    end else if (overrun_c) begin
      state_reg <= atb_pkg::ATB_HALT;
    end else if (nobuf_stop_c && !idle_c) begin
      state_reg <= atb_pkg::ATB_IDLE;
    end else begin
      unique case (state_reg)
        atb_pkg::ATB_IDLE, atb_pkg::ATB_HALT: begin
          if (go_c) begin
            if (start_src_reg != atb_pkg::SRC_SOFT) begin
              state_reg <= atb_pkg::ATB_ARMED;
            end else if (ref_src_reg != atb_pkg::SRC_SOFT) begin
              state_reg <= atb_pkg::ATB_PRE;
            end else begin
              state_reg <= atb_pkg::ATB_RUN;
            end
          end
        end
        atb_pkg::ATB_ARMED: begin
          if (start_hit_c) begin
            state_reg <= (ref_src_reg != atb_pkg::SRC_SOFT) ? atb_pkg::ATB_PRE : atb_pkg::ATB_RUN;
          end
        end
        atb_pkg::ATB_PRE: begin
          if (scan_take_c && ref_hit_c) begin
            state_reg <= (postcnt_reg == '0) ? atb_pkg::ATB_FLUSH : atb_pkg::ATB_POST;
          end
        end
        atb_pkg::ATB_POST: begin
          if (scan_take_c && (post_seen_reg + 32'h1 == postcnt_reg)) begin
            state_reg <= atb_pkg::ATB_FLUSH;
          end
        end
        atb_pkg::ATB_RUN: begin
          state_reg <= atb_pkg::ATB_RUN;
        end
        atb_pkg::ATB_FLUSH: begin
          if (flush_end_c) begin
            state_reg <= atb_pkg::ATB_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      post_seen_reg <= '0;
    end else if (state_reg == atb_pkg::ATB_PRE) begin
      post_seen_reg <= '0;
    end else if (scan_take_c && (state_reg == atb_pkg::ATB_POST)) begin
      post_seen_reg <= post_seen_reg + 32'h1;
    end
  end

  // Host buffer fill count and credits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      buf_cnt_reg <= '0;
    end else if (buf_last_c || partial_c || go_c) begin
      buf_cnt_reg <= '0;
    end else if (take_c) begin
      buf_cnt_reg <= buf_cnt_reg + 32'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      credits_reg <= '0;
    end else begin
      credits_reg <= credits_reg - CW'(buf_last_c || partial_c) +
                     ((wr_en_c && (dp_addr_reg == atb_pkg::OFF_BUFADD)) ? hwdata[CW-1:0] : '0);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      buf_done <= 1'b0;
      buf_partial <= 1'b0;
      overrun_evt <= 1'b0;
      bufs_done_reg <= '0;
    end else begin
      buf_done <= buf_last_c || partial_c;
      buf_partial <= partial_c;
      overrun_evt <= overrun_c;
      bufs_done_reg <= bufs_done_reg + CW'(buf_last_c || partial_c);
    end
  end

  // Sticky status: hardware set wins over a new start
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overrun_reg <= 1'b0;
      nobuf_reg <= 1'b0;
      cfgerr_reg <= 1'b0;
    end else begin
      overrun_reg <= overrun_c || (overrun_reg && !go_c);
      nobuf_reg <= nobuf_stop_c || (nobuf_reg && !go_c);
      cfgerr_reg <= (start_cmd_c && idle_c && !cfg_ok_c) || (cfgerr_reg && !go_c);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      led_amber <= 1'b0;
      led_green <= 1'b0;
    end else begin
      led_amber <= (state_reg == atb_pkg::ATB_ARMED) || (state_reg == atb_pkg::ATB_PRE);
      led_green <= (state_reg == atb_pkg::ATB_POST) || (state_reg == atb_pkg::ATB_RUN) ||
                   (state_reg == atb_pkg::ATB_FLUSH);
    end
  end

  // Configuration registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_src_reg <= atb_pkg::SRC_SOFT;
      ref_src_reg <= atb_pkg::SRC_SOFT;
      thr_ch_reg <= '0;
      level_reg <= atb_pkg::CODE_MID;
      chmask_reg <= '1;
      postcnt_reg <= atb_pkg::RST_POSTCNT;
      bufsize_reg <= atb_pkg::RST_BUFSIZE;
    end else if (wr_en_c) begin
      if (dp_addr_reg == atb_pkg::OFF_TRIG) begin
        start_src_reg <= hwdata[atb_pkg::TRIG_START_LSB +: atb_pkg::SRC_W];
        ref_src_reg <= hwdata[atb_pkg::TRIG_REF_LSB +: atb_pkg::SRC_W];
        thr_ch_reg <= hwdata[atb_pkg::TRIG_CH_LSB +: atb_pkg::CH_SEL_W];
      end
      if (dp_addr_reg == atb_pkg::OFF_LEVEL) level_reg <= hwdata[SW-1:0];
      if (dp_addr_reg == atb_pkg::OFF_CHMASK) chmask_reg <= hwdata[NCH-1:0];
      if (dp_addr_reg == atb_pkg::OFF_POSTCNT) postcnt_reg <= hwdata;
      if ((dp_addr_reg == atb_pkg::OFF_BUFSIZE) && (hwdata != '0)) bufsize_reg <= hwdata;
    end
  end

  // AHB-Lite slave: one wait state per transfer
  logic [31:0] rd_mux_c;
  always_comb begin
    rd_mux_c = '0;
    unique case (dp_addr_reg)
      atb_pkg::OFF_TRIG: begin
        rd_mux_c[atb_pkg::TRIG_START_LSB +: atb_pkg::SRC_W] = start_src_reg;
        rd_mux_c[atb_pkg::TRIG_REF_LSB +: atb_pkg::SRC_W] = ref_src_reg;
        rd_mux_c[atb_pkg::TRIG_CH_LSB +: atb_pkg::CH_SEL_W] = thr_ch_reg;
      end
      atb_pkg::OFF_LEVEL: rd_mux_c[SW-1:0] = level_reg;
      atb_pkg::OFF_CHMASK: rd_mux_c[NCH-1:0] = chmask_reg;
      atb_pkg::OFF_POSTCNT: rd_mux_c = postcnt_reg;
      atb_pkg::OFF_BUFSIZE: rd_mux_c = bufsize_reg;
      atb_pkg::OFF_BUFADD: rd_mux_c[CW-1:0] = credits_reg;
      atb_pkg::OFF_STATUS: begin
        rd_mux_c[atb_pkg::ST_BUSY] = !idle_c;
        rd_mux_c[atb_pkg::ST_ARMED] = led_amber;
        rd_mux_c[atb_pkg::ST_TRIGGERED] = led_green;
        rd_mux_c[atb_pkg::ST_OVERRUN] = overrun_reg;
        rd_mux_c[atb_pkg::ST_NOBUF] = nobuf_reg;
        rd_mux_c[atb_pkg::ST_CFGERR] = cfgerr_reg;
        rd_mux_c[atb_pkg::ST_BUFCNT_LSB +: CW] = bufs_done_reg;
      end
      atb_pkg::OFF_FIFOLVL: rd_mux_c[LW-1:0] = fifo_level;
      default: rd_mux_c = '0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_pend_reg <= 1'b0;
      dp_write_reg <= 1'b0;
      dp_word_reg <= 1'b0;
      dp_addr_reg <= '0;
      hreadyout <= 1'b1;
      hresp <= atb_pkg::HRESP_OKAY;
      hrdata <= '0;
    end else begin
      hresp <= atb_pkg::HRESP_OKAY;
      if (dp_pend_reg) begin
        dp_pend_reg <= 1'b0;
        hreadyout <= 1'b1;
        hrdata <= dp_write_reg ? 32'h0 : rd_mux_c;
      end else if (hsel && htrans[1] && hready) begin
        dp_pend_reg <= 1'b1;
        dp_write_reg <= hwrite;
        dp_word_reg <= (hsize == atb_pkg::HSIZE_WORD) && (haddr[31:atb_pkg::ADDR_W] == '0);
        dp_addr_reg <= haddr[atb_pkg::ADDR_W-1:0];
        hreadyout <= 1'b0;
      end
    end
  end
endmodule

/* atb_pkg.sv */
package atb_pkg;
  localparam int SAMPLE_W = 24;
  localparam logic [SAMPLE_W-1:0] CODE_NEG_FS = 24'h000000;
  localparam logic [SAMPLE_W-1:0] CODE_POS_FS = 24'hffffff;
  localparam logic [SAMPLE_W-1:0] CODE_MID = 24'h800000;
  localparam int FIFO_DEPTH_DEF = 16384;

  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_TRIG = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_LEVEL = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_CHMASK = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_POSTCNT = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_BUFSIZE = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_BUFADD = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h1c;
  localparam logic [ADDR_W-1:0] OFF_FIFOLVL = 8'h20;

  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_ABORT_BIT = 1;
  localparam int TRIG_START_LSB = 0;
  localparam int TRIG_REF_LSB = 4;
  localparam int TRIG_CH_LSB = 8;
  localparam int SRC_W = 3;
  localparam int CH_SEL_W = 8;

  localparam logic [SRC_W-1:0] SRC_SOFT = 3'h0;
  localparam logic [SRC_W-1:0] SRC_EXT_POS = 3'h1;
  localparam logic [SRC_W-1:0] SRC_EXT_NEG = 3'h2;
  localparam logic [SRC_W-1:0] SRC_THR_POS = 3'h3;
  localparam logic [SRC_W-1:0] SRC_THR_NEG = 3'h4;

  localparam int ST_BUSY = 0;
  localparam int ST_ARMED = 1;
  localparam int ST_TRIGGERED = 2;
  localparam int ST_OVERRUN = 3;
  localparam int ST_NOBUF = 4;
  localparam int ST_CFGERR = 5;
  localparam int ST_BUFCNT_LSB = 16;
  localparam int CNT_W = 16;

  localparam logic [31:0] RST_BUFSIZE = 32'h00000400;
  localparam logic [31:0] RST_POSTCNT = 32'h00000001;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [2:0] {
    ATB_IDLE, ATB_ARMED, ATB_PRE, ATB_POST, ATB_RUN, ATB_FLUSH, ATB_HALT
  } atb_state_t;
endpackage

/* atb_fifo.sv */
`timescale 1ns/10ps
module atb_fifo #(
  parameter int W = 24,
  parameter int DEPTH = 16384
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  // Fill side
  input wire logic wr_valid,
  input wire logic [W-1:0] wr_data,
  output logic wr_ready,
  // Drain side
  input wire logic rd_allow,
  output logic rd_valid,
  output logic [W-1:0] rd_data,
  input wire logic rd_ready,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wptr_reg;
  logic [AW:0] rptr_reg;
  logic empty_c;
  logic load_c;
  logic push_c;

  assign empty_c = (wptr_reg == rptr_reg);
  assign wr_ready = !((wptr_reg[AW] != rptr_reg[AW]) && (wptr_reg[AW-1:0] == rptr_reg[AW-1:0]));
  assign level = wptr_reg - rptr_reg;
  assign push_c = wr_valid && wr_ready && !clear;
  // Output word reloads only while the drain side is allowed to move
  assign load_c = rd_allow && !empty_c && (!rd_valid || rd_ready) && !clear;

  always_ff @(posedge clk) begin
    if (push_c) begin
      mem[wptr_reg[AW-1:0]] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr_reg <= '0;
    end else if (clear) begin
      wptr_reg <= '0;
    end else if (push_c) begin
      wptr_reg <= wptr_reg + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rptr_reg <= '0;
    end else if (clear) begin
      rptr_reg <= '0;
    end else if (load_c) begin
      rptr_reg <= rptr_reg + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_valid <= 1'b0;
      rd_data <= '0;
    end else if (clear) begin
      rd_valid <= 1'b0;
    end else if (load_c) begin
      rd_valid <= 1'b1;
      rd_data <= mem[rptr_reg[AW-1:0]];
    end else if (rd_ready || !rd_allow) begin
      rd_valid <= 1'b0;
    end
  end
endmodule

/* atb_acq_properties.sv */
`timescale 1ns/10ps
module atb_acq_checker (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Stream
  input wire logic host_valid,
  input wire logic host_ready,
  input wire logic [23:0] host_data,
  // Events and lamp
  input wire logic buf_done,
  input wire logic buf_partial,
  input wire logic overrun_evt,
  input wire logic led_amber,
  input wire logic led_green
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  lamp_excl_a: assert property (!(led_amber && led_green)) else $error("two lamps");
  done_pulse_a: assert property (buf_done |=> !buf_done) else $error("long done");
  done_take_a: assert property (buf_done && !buf_partial |-> $past(host_valid & host_ready))
    else $error("done without take");
  partial_done_a: assert property (buf_partial |-> buf_done) else $error("lone partial");
  ovr_pulse_a: assert property (overrun_evt |=> !overrun_evt) else $error("long overrun");
  ovr_stop_a: assert property (overrun_evt |-> ##2 !host_valid [*3])
    else $error("sent after overrun");
  ovr_dark_a: assert property (overrun_evt |-> ##2 !led_amber && !led_green)
    else $error("lamp lit");
  data_hold_a: assert property (host_valid && !host_ready |=> !host_valid || $stable(host_data))
    else $error("data moved");
  cover property ($rose(led_green));
  cover property (buf_done && buf_partial);
  cover property (overrun_evt);
endmodule
bind atb_acq_top atb_acq_checker atb_acq_checker_i (.hclk(hclk), .hresetn(hresetn),
  .host_valid(host_valid), .host_ready(host_ready), .host_data(host_data), .buf_done(buf_done),
  .buf_partial(buf_partial), .overrun_evt(overrun_evt), .led_amber(led_amber),
  .led_green(led_green));

/* atb_host_model.sv */
`timescale 1ns/10ps
module atb_host_model (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Stream
  input wire logic host_valid,
  input wire logic [23:0] host_data,
  output logic host_ready,
  // Pace and observation
  input wire logic slow,
  output logic [23:0] last_data,
  output int takes
);
  // Slow host accepts only every other cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      host_ready <= 1'b0;
      takes <= 0;
      last_data <= 24'h000000;
    end else begin
      host_ready <= slow ? ~host_ready : 1'b1;
      if (host_valid && host_ready) begin
        takes <= takes + 1;
        last_data <= host_data;
      end
    end
  end
endmodule

/* tb_acq_trigger_buffer_control.sv */
`timescale 1ns/10ps
module tb_acq_trigger_buffer_control;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, adc_scan_valid, ext_trig, slow;
  logic host_valid, host_ready, buf_done, buf_partial, overrun_evt, led_amber, led_green;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [103:0] adc_raw;
  logic [23:0] host_data, last_data;
  logic [25:0] raw_in [6] = '{26'h37ffffb, 26'h3800000, 26'h3ffffff, 26'h5, 26'h7fffff, 26'h800000};
  logic [23:0] code_out [6] = '{24'h0, 24'h0, 24'h7fffff, 24'h800005, 24'hffffff, 24'hffffff};
  int takes, t0, err_count, compares, n_done, n_part, n_ovr;

  atb_acq_top #(.FIFO_DEPTH(16)) atb_acq_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .adc_scan_valid(adc_scan_valid), .adc_raw(adc_raw), .ext_trig(ext_trig),
    .host_valid(host_valid), .host_data(host_data), .host_ready(host_ready),
    .buf_done(buf_done), .buf_partial(buf_partial), .overrun_evt(overrun_evt),
    .led_amber(led_amber), .led_green(led_green));
  atb_host_model atb_host_model_i (.hclk(hclk), .hresetn(hresetn), .host_valid(host_valid),
    .host_data(host_data), .host_ready(host_ready), .slow(slow), .last_data(last_data),
    .takes(takes));

  initial begin
    hclk = 0;
    forever #2.5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    n_done += (buf_done === 1'b1);
    n_part += (buf_partial === 1'b1);
    n_ovr += (overrun_evt === 1'b1);
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task scan(input logic [25:0] v);
    adc_scan_valid <= 1'b1;
    adc_raw <= {78'h0, v};
    @(posedge hclk);
    adc_scan_valid <= 1'b0;
    repeat (8) @(posedge hclk);
  endtask
  task results;
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    {hresetn, hsel, haddr, htrans, hwrite, hwdata, adc_scan_valid, adc_raw, ext_trig, slow} = 0;
    hsize = 3'h2;
    {err_count, compares, n_done, n_part, n_ovr} = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({led_amber, led_green, buf_done, overrun_evt}, 0);
    bus(1, atb_pkg::OFF_CHMASK, 1);
    bus(1, atb_pkg::OFF_BUFADD, 3);
    bus(1, atb_pkg::OFF_CTRL, 1);
    for (int i = 0; i < 6; i++) begin
      scan(raw_in[i]);
      chk(last_data, code_out[i]);
    end
    chk(takes, 6);
    $display("test coding done");
    bus(1, atb_pkg::OFF_CTRL, 2);
    slow <= 1'b1;
    scan(26'h5);
    chk({8'(n_part), 8'(led_green), 8'(takes)}, {8'd1, 8'd0, 8'd6});
    $display("test abort done");
    bus(1, atb_pkg::OFF_BUFSIZE, 2);
    bus(1, atb_pkg::OFF_CTRL, 1);
    for (int j = 0; j < 5; j++) scan(26'(j));
    bus(0, atb_pkg::OFF_STATUS, 0);
    chk({4'(n_done), 4'(takes), last_data}, {4'd3, 4'd10, 24'h800003});
    chk({hresp, rd[4]}, 2'b01);
    $display("test buffers done");
    bus(1, atb_pkg::OFF_CHMASK, 32'hf);
    bus(1, atb_pkg::OFF_CTRL, 1);
    for (int j = 0; j < 6; j++) scan(26'h9);
    bus(0, atb_pkg::OFF_STATUS, 0);
    chk({8'(n_ovr), 8'(takes), 8'(led_green)}, {8'd1, 8'd10, 8'd0});
    chk(rd[3], 1);
    $display("test overrun done");
    for (int p = 1; p < 3; p++) begin
      bus(1, atb_pkg::OFF_TRIG, p);
      bus(1, atb_pkg::OFF_CTRL, 1);
      @(posedge hclk);
      chk({led_amber, led_green}, 2'b10);
      ext_trig <= ~ext_trig;
      repeat (6) @(posedge hclk);
      chk({led_amber, led_green}, 2'b01);
      bus(1, atb_pkg::OFF_CTRL, 2);
    end
    $display("test external done");
    bus(1, atb_pkg::OFF_BUFSIZE, 32'h64);
    for (int p = 0; p < 2; p++) begin
      bus(1, atb_pkg::OFF_BUFADD, 1);
      bus(1, atb_pkg::OFF_LEVEL, p ? 32'h7fff9c : 32'h800064);
      bus(1, atb_pkg::OFF_TRIG, p ? 32'h40 : 32'h30);
      t0 = takes;
      bus(1, atb_pkg::OFF_CTRL, 1);
      scan(26'h0);
      scan(p ? -26'd50 : 26'd50);
      chk({led_amber, led_green}, 2'b10);
      scan(p ? -26'd200 : 26'd200);
      chk({led_amber, led_green}, 2'b01);
      scan(26'h0);
      scan(26'h0);
      repeat (30) @(posedge hclk);
      chk({16'(takes - t0), 16'(led_green)}, {16'd16, 16'd0});
    end
    $display("test threshold done");
    bus(1, atb_pkg::OFF_TRIG, 32'h530);
    bus(1, atb_pkg::OFF_CTRL, 1);
    bus(0, atb_pkg::OFF_STATUS, 0);
    chk(rd[5:0], 6'h20);
    $display("test config error done");
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk({led_amber, led_green, buf_done, host_valid, hreadyout}, 5'h01);
    hresetn <= 1'b1;
    @(posedge hclk);
    $display("test reset done");
    results();
  end
  initial begin
    repeat (20000) @(posedge hclk);
    err_count++;
    $display("[FAIL] %0t watchdog", $time);
    results();
  end
endmodule
